/* File: design/wpef_event_flags.sv */
`timescale 1ns/100ps
module wpef_event_flags
  import wpef_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire wpef_events_t      events,
  output logic                   host_processor_irq
);

  //////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [1:0]    rresp;
    logic [31:0]   rdata;
    logic [5:0]    aw_idx;
    logic          aw_got;
    logic          w_got;
    logic [7:0]    wbyte;
    logic          wbyte_en;
    wpef_tx_low_t  tx_low;
    logic [7:0]    tx_pkt;
    wpef_rx_high_t rx_high;
    wpef_rx_mid_t  rx_mid;
    logic [7:0]    en_high;
    logic [7:0]    en_mid;
    logic [7:0]    clr_tx_low;
    logic [7:0]    clr_tx_pkt;
    logic [7:0]    clr_rx_high;
    logic [7:0]    clr_rx_mid;
    logic [7:0]    ept_reason;
    logic          prev_mode;
    logic          prev_power;
    logic          irq;
  } wpef_state_t;

  wpef_state_t state;
  wpef_state_t next_state;

  // Set terms and mode qualifiers, shared by the flag update below.
  logic          rx_mode;
  logic [7:0]    set_tx_low;
  logic [7:0]    set_tx_pkt;
  logic [7:0]    set_rx_high;
  logic [7:0]    set_rx_mid;
  logic [7:0]    hold_rx_high;
  logic [7:0]    level_rx_high;
  wpef_tx_low_t  tx_ev;
  wpef_rx_high_t rx_ev;
  logic [5:0]    ar_idx;

  //////////////////////////////////////////////////////////////////////////

  // Event qualification: each event only counts in the mode it belongs to, except mode change and rectifier power, which count in either mode.
  always_comb begin
    rx_mode = ~events.tx_mode;
    tx_ev = events.tx_low;
    // Mode change is caught from the mode level itself, in either mode.
    tx_ev.operating_mode_changed_flag = events.tx_mode ^ state.prev_mode;
    set_tx_low = tx_ev & {8{events.tx_mode}};
    set_tx_low[$bits(wpef_tx_low_t)-3] = tx_ev.operating_mode_changed_flag;
    set_tx_pkt = {7'h00, events.charge_status_packet & events.tx_mode};
    rx_ev = events.rx_high;
    // Rectifier power only counts on its rising edge, in any mode.
    rx_ev.rectifier_power_present_flag =
      events.rx_high.rectifier_power_present_flag & ~state.prev_power;
    rx_ev.current_near_limit_flag = 1'b0;
    set_rx_high = rx_ev & {8{rx_mode}} & RX_HIGH_MASK;
    set_rx_high[$bits(wpef_rx_high_t)-6] =
      rx_ev.rectifier_power_present_flag;
    set_rx_mid = events.rx_mid & {8{rx_mode}} & RX_MID_MASK;
    // Sticky bits survive unless cleared; the rectifier bit also needs power.
    hold_rx_high = state.rx_high & ~state.clr_rx_high;
    hold_rx_high[$bits(wpef_rx_high_t)-6] =
      state.rx_high.rectifier_power_present_flag &
      ~state.clr_rx_high[$bits(wpef_rx_high_t)-6] &
      events.rx_high.rectifier_power_present_flag;
    // The current warning is a live level, never latched.
    level_rx_high = '0;
    level_rx_high[$bits(wpef_rx_high_t)-1] =
      events.rx_high.current_near_limit_flag & rx_mode;
    hold_rx_high[$bits(wpef_rx_high_t)-1] = 1'b0;
    ar_idx = s_axi_araddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
  end

  //////////////////////////////////////////////////////////////////////////

  // Next state: bus slave, flag update and interrupt output.
  always_comb begin
    next_state = state;

    // Pending clear bits act once, then fall back to zero.
    next_state.clr_tx_low  = '0;
    next_state.clr_tx_pkt  = '0;
    next_state.clr_rx_high = '0;
    next_state.clr_rx_mid  = '0;

    // Write address and data are taken independently, in either order.
    if (s_axi_awvalid && state.awready) begin
      next_state.aw_idx  = s_axi_awaddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
      next_state.aw_got  = 1'b1;
      next_state.awready = 1'b0;
    end
    if (s_axi_wvalid && state.wready) begin
      next_state.wbyte    = s_axi_wdata[7:0];
      next_state.wbyte_en = s_axi_wstrb[0];
      next_state.w_got    = 1'b1;
      next_state.wready   = 1'b0;
    end

    // Once both halves are in, perform the write and answer.
    if (state.aw_got && state.w_got && !state.bvalid) begin
      next_state.aw_got = 1'b0;
      next_state.w_got  = 1'b0;
      next_state.bvalid = 1'b1;
      next_state.bresp  = RESP_OKAY;
      unique case (state.aw_idx)
        IDX_TX_CLR_LOW: begin
          if (state.wbyte_en) begin
            next_state.clr_tx_low = state.wbyte & TX_LOW_MASK;
          end
        end
        IDX_TX_CLR_PKT: begin
          if (state.wbyte_en) begin
            next_state.clr_tx_pkt = state.wbyte & TX_PKT_MASK;
          end
        end
        IDX_RX_CLR_HIGH: begin
          if (state.wbyte_en) begin
            next_state.clr_rx_high = state.wbyte & RX_HIGH_MASK;
          end
        end
        IDX_RX_CLR_MID: begin
          if (state.wbyte_en) begin
            next_state.clr_rx_mid = state.wbyte & RX_MID_MASK;
          end
        end
        IDX_RX_EN_HIGH: begin
          if (state.wbyte_en) begin
            next_state.en_high = state.wbyte & RX_HIGH_MASK;
          end
        end
        IDX_RX_EN_MID: begin
          if (state.wbyte_en) begin
            next_state.en_mid = state.wbyte & RX_MID_MASK;
          end
        end
        // Flag, spare and reason bytes are read-only: the write is answered and dropped.
        IDX_TX_STAT_LOW, IDX_TX_STAT_PKT, IDX_TX_SPARE_A, IDX_TX_SPARE_B,
        IDX_RX_MID, IDX_RX_HIGH, IDX_RX_SPARE, IDX_EPT_REASON: begin
          next_state.bresp = RESP_OKAY;
        end
        default: begin
          next_state.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (state.bvalid && s_axi_bready) begin
      next_state.bvalid  = 1'b0;
      next_state.awready = 1'b1;
      next_state.wready  = 1'b1;
    end

    // Read: the word is captured at the address handshake.
    if (s_axi_arvalid && state.arready) begin
      next_state.arready = 1'b0;
      next_state.rvalid  = 1'b1;
      next_state.rresp   = RESP_OKAY;
      next_state.rdata   = '0;
      unique case (ar_idx)
        IDX_TX_CLR_LOW:  next_state.rdata[7:0] = state.clr_tx_low;
        IDX_TX_CLR_PKT:  next_state.rdata[7:0] = state.clr_tx_pkt;
        IDX_RX_CLR_HIGH: next_state.rdata[7:0] = state.clr_rx_high;
        IDX_RX_CLR_MID:  next_state.rdata[7:0] = state.clr_rx_mid;
        IDX_RX_EN_HIGH:  next_state.rdata[7:0] = state.en_high;
        IDX_RX_EN_MID:   next_state.rdata[7:0] = state.en_mid;
        IDX_TX_STAT_LOW: next_state.rdata[7:0] = state.tx_low;
        IDX_TX_STAT_PKT: next_state.rdata[7:0] = state.tx_pkt & TX_PKT_MASK;
        IDX_RX_HIGH:     next_state.rdata[7:0] = state.rx_high & RX_HIGH_MASK;
        IDX_RX_MID:      next_state.rdata[7:0] = state.rx_mid & RX_MID_MASK;
        IDX_EPT_REASON:  next_state.rdata[7:0] = state.ept_reason;
        IDX_TX_SPARE_A, IDX_TX_SPARE_B, IDX_RX_SPARE: begin
          next_state.rdata = '0;
        end
        default: begin
          next_state.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (state.rvalid && s_axi_rready) begin
      next_state.rvalid  = 1'b0;
      next_state.arready = 1'b1;
    end

    // Flags: a set in the clearing cycle wins over the clear.
    next_state.tx_low = (state.tx_low & ~state.clr_tx_low) | set_tx_low;
    next_state.tx_pkt = ((state.tx_pkt & ~state.clr_tx_pkt) | set_tx_pkt)
                        & TX_PKT_MASK;
    next_state.rx_high = (hold_rx_high | set_rx_high | level_rx_high)
                         & RX_HIGH_MASK;
    next_state.rx_mid = ((state.rx_mid & ~state.clr_rx_mid) | set_rx_mid)
                        & RX_MID_MASK;
    if (set_tx_low[0]) begin
      next_state.ept_reason = events.ept_reason;
    end
    next_state.prev_mode  = events.tx_mode;
    next_state.prev_power = events.rx_high.rectifier_power_present_flag;

    // Transmit flags have no mask; receive flags pass their enables.
    next_state.irq = (|next_state.tx_low) | (|next_state.tx_pkt) |
                     (|(next_state.rx_high & next_state.en_high)) |
                     (|(next_state.rx_mid & next_state.en_mid));
  end

  //////////////////////////////////////////////////////////////////////////

  // State register; reset takes constants only.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state            <= '0;
      state.awready    <= 1'b1;
      state.wready     <= 1'b1;
      state.arready    <= 1'b1;
      state.bresp      <= RESP_OKAY;
      state.rresp      <= RESP_OKAY;
      state.tx_low     <= FLAGS_RST;
      state.tx_pkt     <= FLAGS_RST;
      state.rx_high    <= FLAGS_RST;
      state.rx_mid     <= FLAGS_RST;
      state.en_high    <= EN_HIGH_RST;
      state.en_mid     <= EN_MID_RST;
    end else begin
      state <= next_state;
    end
  end

  // Outputs come straight from the state register.
  assign s_axi_awready      = state.awready;
  assign s_axi_wready       = state.wready;
  assign s_axi_bvalid       = state.bvalid;
  assign s_axi_bresp        = state.bresp;
  assign s_axi_arready      = state.arready;
  assign s_axi_rvalid       = state.rvalid;
  assign s_axi_rresp        = state.rresp;
  assign s_axi_rdata        = state.rdata;
  assign host_processor_irq = state.irq;

endmodule

/* File: pkg/wpef_pkg.sv */
package wpef_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_TX_CLR_LOW  = 6'h28;
  localparam logic [5:0] IDX_TX_CLR_PKT  = 6'h29;
  localparam logic [5:0] IDX_TX_STAT_LOW = 6'h2c;
  localparam logic [5:0] IDX_TX_STAT_PKT = 6'h2d;
  localparam logic [5:0] IDX_TX_SPARE_A  = 6'h2e;
  localparam logic [5:0] IDX_TX_SPARE_B  = 6'h2f;
  localparam logic [5:0] IDX_RX_MID      = 6'h31;
  localparam logic [5:0] IDX_RX_HIGH     = 6'h32;
  localparam logic [5:0] IDX_RX_SPARE    = 6'h33;
  localparam logic [5:0] IDX_RX_EN_MID   = 6'h35;
  localparam logic [5:0] IDX_RX_EN_HIGH  = 6'h36;
  localparam logic [5:0] IDX_RX_CLR_MID  = 6'h38;
  localparam logic [5:0] IDX_RX_CLR_HIGH = 6'h39;
  localparam logic [5:0] IDX_EPT_REASON  = 6'h3c;

  // Bits of the index field inside a byte address.
  localparam int ADDR_IDX_LSB = 2;
  localparam int ADDR_IDX_MSB = 7;

  // Implemented bits of each byte; the others read as zero.
  localparam logic [7:0] TX_LOW_MASK  = 8'hff;
  localparam logic [7:0] TX_PKT_MASK  = 8'h01;
  localparam logic [7:0] RX_HIGH_MASK = 8'hfc;
  localparam logic [7:0] RX_MID_MASK  = 8'hf0;

  // Reset values.
  localparam logic [7:0] FLAGS_RST    = 8'h00;
  localparam logic [7:0] EN_HIGH_RST  = 8'h7c;
  localparam logic [7:0] EN_MID_RST   = 8'hf0;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Transmit-mode flag byte, most significant bit first.
  typedef struct packed {
    logic tx_init_done_flag;
    logic placed_on_other_transmitter_flag;
    logic operating_mode_changed_flag;
    logic configuration_packet_flag;
    logic identification_packet_flag;
    logic signal_strength_packet_flag;
    logic digital_ping_started_flag;
    logic end_power_transfer_flag;
  } wpef_tx_low_t;

  // Receive-mode flag byte at the higher offset.
  typedef struct packed {
    logic       current_near_limit_flag;
    logic       channel_error_flag;
    logic       channel_data_received_flag;
    logic       channel_data_sent_flag;
    logic       thermistor_over_threshold_flag;
    logic       rectifier_power_present_flag;
    logic [1:0] spare;
  } wpef_rx_high_t;

  // Receive-mode flag byte at the lower offset.
  typedef struct packed {
    logic       voltage_switch_failed_flag;
    logic       receiver_sleeping_flag;
    logic       identity_auth_pass_flag;
    logic       identity_auth_fail_flag;
    logic [3:0] spare;
  } wpef_rx_mid_t;

  // Events and levels from the power core, one clock domain.
  typedef struct packed {
    logic          tx_mode;
    wpef_tx_low_t  tx_low;
    logic          charge_status_packet;
    wpef_rx_high_t rx_high;
    wpef_rx_mid_t  rx_mid;
    logic [7:0]    ept_reason;
  } wpef_events_t;

endpackage

/* File: tb/wpef_host_model.sv */
`timescale 1ns/100ps
// Host processor model: one write and one read at a time over the bus.
module wpef_host_model (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // Idle bus at time zero.
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
  end
  //////////////////////////////////////////////////////////////////////
  // Address and data go out together; each drops when taken.
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    {awvalid, wvalid, bready} <= 3'h7;
    while (!b) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        b = 1'b1;
        r = bresp;
        bready <= 1'b0;
      end
    end
  endtask
  // Read waits for its answer with rready held high.
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic b;
    b = 1'b0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (!b) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        b = 1'b1;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
      end
    end
  endtask
endmodule

/* File: tb/wpef_event_flags_assertions.sv */
`timescale 1ns/100ps
// Bus timing and event-to-interrupt relations seen at the ports.
module wpef_event_flags_assertions
  import wpef_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic         aclk,
  input wire logic         aresetn,
  input wire logic         s_axi_awvalid,
  input wire logic         s_axi_awready,
  input wire logic         s_axi_wvalid,
  input wire logic         s_axi_wready,
  input wire logic [1:0]   s_axi_bresp,
  input wire logic         s_axi_bvalid,
  input wire logic         s_axi_bready,
  input wire logic         s_axi_arvalid,
  input wire logic         s_axi_arready,
  input wire logic [31:0]  s_axi_rdata,
  input wire logic [1:0]   s_axi_rresp,
  input wire logic         s_axi_rvalid,
  input wire logic         s_axi_rready,
  input wire wpef_events_t events,
  input wire logic         host_processor_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A write is taken in two steps that may share one edge.
  sequence s_aw;
    s_axi_awvalid && s_axi_awready;
  endsequence
  sequence s_wboth;
    s_aw ##0 (s_axi_wvalid && s_axi_wready);
  endsequence
  property p_aw_drop; s_aw |=> !s_axi_awready; endproperty
  property p_b_time; s_wboth |-> ##2 s_axi_bvalid; endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  property p_tx_irq;
    events.tx_mode && (events.tx_low & 8'hdf) != 8'h0 |=> host_processor_irq;
  endproperty
  property p_csp_irq;
    events.tx_mode && events.charge_status_packet |=> host_processor_irq;
  endproperty
  property p_rx_irq;
    !events.tx_mode && (events.rx_mid & RX_MID_MASK) != 8'h0
      |=> host_processor_irq;
  endproperty
  property p_rect;
    $rose(events.rx_high.rectifier_power_present_flag) |=> host_processor_irq;
  endproperty
  a_aw_drop: assert property (p_aw_drop)
    else $error("write address ready stayed high after take");
  a_b_time: assert property (p_b_time)
    else $error("write response late");
  a_b_hold: assert property (p_b_hold)
    else $error("write response not held");
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  a_r_upper: assert property (p_r_upper)
    else $error("upper read bits not zero");
  a_err_zero: assert property (p_err_zero)
    else $error("error read returned data");
  a_tx_irq: assert property (p_tx_irq)
    else $error("transmit event raised no interrupt");
  a_csp_irq: assert property (p_csp_irq)
    else $error("charge status event raised no interrupt");
  a_rx_irq: assert property (p_rx_irq)
    else $error("receive event raised no interrupt");
  a_rect: assert property (p_rect)
    else $error("rectifier power rise raised no interrupt");
endmodule
bind wpef_event_flags wpef_event_flags_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .events(events), .host_processor_irq(host_processor_irq));

/* File: tb/wpef_event_flags_bench.sv */
`timescale 1ns/100ps
module wpef_event_flags_bench
  import wpef_pkg::*;
;
  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  wpef_events_t ev = '0;
  logic [7:0]   awaddr, araddr, m, mm, hh, r;
  logic [31:0]  wdata, rdata, rd_d;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp, rsp;
  logic         awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, irq;
  int           n_mismatch = 0;
  int           cmp_count = 0;
  logic [7:0]   ridx [12] = '{8'h28, 8'h29, 8'h2c, 8'h2d, 8'h2e, 8'h2f,
                              8'h31, 8'h32, 8'h33, 8'h3c, 8'h35, 8'h36};
  logic [7:0]   rexp [12] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0,
                              8'h0, 8'h0, 8'h0, EN_MID_RST, EN_HIGH_RST};
  // Free-running 200 MHz clock.
  always #2.5 aclk = ~aclk;
  wpef_event_flags dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .events(ev),
    .host_processor_irq(irq));
  wpef_host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  //////////////////////////////////////////////////////////////////////
  // Interrupt level expected from set flags and the enable masks.
  function automatic logic exp_irq(logic [7:0] t, logic [7:0] h,
                                   logic [7:0] l, logic [7:0] en);
    return (t != 8'h0) || ((h & en & RX_HIGH_MASK) != 8'h0) ||
           ((l & EN_MID_RST) != 8'h0);
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    host.rd({idx[5:0], 2'b00}, rd_d, rsp);
    chk($sformatf("reg %h", idx), rd_d, {24'h0, e});
    chk("read resp", {30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask
  task automatic wrc(input logic [7:0] idx, input logic [7:0] d);
    host.wr({idx[5:0], 2'b00}, d, rsp);
    chk("write response", {30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask
  // One-cycle event pulses, then a cycle for the flags to land.
  task automatic pulse(logic [7:0] t, logic c, logic [7:0] h, logic [7:0] l);
    @(posedge aclk);
    ev.tx_low <= t;
    ev.charge_status_packet <= c;
    ev.rx_high <= ev.rx_high | h;
    ev.rx_mid <= l;
    @(posedge aclk);
    ev.tx_low <= 8'h0;
    ev.charge_status_packet <= 1'b0;
    ev.rx_high <= ev.rx_high & ~h;
    ev.rx_mid <= 8'h0;
    @(posedge aclk);
  endtask
  task automatic lvl(logic [7:0] h);
    @(posedge aclk);
    ev.rx_high <= h;
    repeat (2) @(posedge aclk);
  endtask
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    stop_test;
  end
  // Main sequence: reset values, transmit flags, receive flags, masks.
  initial begin
    void'($urandom(32'h548b));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ridx[i]) rdc(ridx[i], rexp[i]);
    host.rd(8'h00, rd_d, rsp);
    chk("unmapped resp", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    chk("unmapped data", rd_d, 32'h0);
    host.wr(8'h00, 8'hff, rsp);
    chk("unmapped write", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    ev.tx_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    rdc(8'h2c, 8'h20);
    wrc(8'h28, 8'h20);
    for (int i = 0; i < 4; i++) begin
      m = (i == 0) ? 8'hdf : 8'($urandom) & 8'hdf;
      r = 8'($urandom);
      ev.ept_reason <= r;
      pulse(m, 1'b0, 8'h0, 8'h0);
      rdc(8'h2c, m);
      chk("irq", {31'h0, irq},
          {31'h0, exp_irq(m, 8'h0, 8'h0, 8'h0)});
      if (m[0]) rdc(8'h3c, r);
      wrc(8'h2c, 8'hff);
      rdc(8'h2c, m);
      wrc(8'h28, m);
      rdc(8'h28, 8'h00);
      rdc(8'h2c, 8'h00);
    end
    pulse(8'h0, 1'b1, 8'h0, 8'h0);
    rdc(8'h2d, 8'h01);
    wrc(8'h29, 8'h01);
    rdc(8'h2d, 8'h00);
    chk("irq", {31'h0, irq}, 32'h0);
    ev.tx_mode <= 1'b0;
    repeat (3) @(posedge aclk);
    rdc(8'h2c, 8'h20);
    wrc(8'h28, 8'h20);
    for (int i = 0; i < 3; i++) begin
      mm = (i == 0) ? 8'hf0 : 8'($urandom) & 8'hf0;
      hh = (i == 0) ? 8'h78 : 8'($urandom) & 8'h78;
      pulse(8'h0, 1'b0, hh, mm);
      rdc(8'h31, mm);
      rdc(8'h32, hh);
      chk("irq", {31'h0, irq},
          {31'h0, exp_irq(8'h0, hh, mm, EN_HIGH_RST)});
      wrc(8'h38, mm);
      wrc(8'h39, hh);
      rdc(8'h31, 8'h00);
      rdc(8'h32, 8'h00);
    end
    lvl(8'h80);
    rdc(8'h32, 8'h80);
    chk("irq", {31'h0, irq}, 32'h0);
    lvl(8'h00);
    rdc(8'h32, 8'h00);
    lvl(8'h04);
    rdc(8'h32, 8'h04);
    chk("irq", {31'h0, irq}, 32'h1);
    lvl(8'h00);
    rdc(8'h32, 8'h00);
    chk("irq", {31'h0, irq}, 32'h0);
    wrc(8'h36, 8'h00);
    pulse(8'h0, 1'b0, 8'h40, 8'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    rdc(8'h32, 8'h40);
    wrc(8'h36, EN_HIGH_RST);
    repeat (2) @(posedge aclk);
    chk("irq", {31'h0, irq}, 32'h1);
    wrc(8'h39, 8'h40);
    repeat (2) @(posedge aclk);
    chk("irq", {31'h0, irq}, 32'h0);
    stop_test;
  end
endmodule
